// file: core/dci_defs.svh
// offsets, field positions, reset values and sizes of the debug channel interrupt block
`ifndef DCI_DEFS_SVH
`define DCI_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DCI_OFS_RX_FEATURE 12'h00C
`define DCI_OFS_ICS 12'h010
`define DCI_OFS_MASK 12'h014
`define DCI_OFS_DATA 12'h020

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCI_ICS_RXF 31
`define DCI_ICS_RXL_HI 19
`define DCI_ICS_RXL_LO 16
`define DCI_ICS_TXF 15
`define DCI_ICS_TXL_HI 3
`define DCI_ICS_TXL_LO 0
`define DCI_FEAT_DEPTH_HI 19
`define DCI_FEAT_DEPTH_LO 16
`define DCI_FEAT_IRQ 1
`define DCI_FEAT_PRESENT 0

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define DCI_RXL_RESET 4'h1
`define DCI_TXL_RESET 4'h0
`define DCI_FIFO_AW 4
`define DCI_FIFO_DEPTH 5'h10
`define DCI_RX_DEPTH_CODE 4'h4
`define DCI_NULL_BYTE 8'h00

`endif

// file: core/dci_pkg.sv
// types shared by the debug channel interrupt block
package dci_pkg;
  // apb slave sequencing: take request, load answer, present answer
  typedef enum logic [1:0] {
    DCI_S_IDLE = 2'b00,
    DCI_S_LOAD = 2'b01,
    DCI_S_DONE = 2'b10
  } dci_state_t;
endpackage

// file: core/dci_byte_fifo.sv
// byte fifo storage with registered read data and an occupancy count
`include "dci_defs.svh"

module dci_byte_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] pop_data,
  output logic [4:0] count
);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [7:0] mem [0:15]; // byte slots, no reset needed
  logic [`DCI_FIFO_AW-1:0] wptr; // next slot to fill
  logic [`DCI_FIFO_AW-1:0] rptr; // oldest byte

  // storage write; the caller never pushes into a full fifo
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr] <= push_data;
    end
  end

  // pointers and count; the caller never pops an empty fifo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= '0;
      rptr <= '0;
      count <= 5'h00;
    end else begin
      if (push) begin
        wptr <= wptr + 4'h1;
      end
      if (pop) begin
        rptr <= rptr + 4'h1;
      end
      count <= 5'(count + {4'h0, push} - {4'h0, pop});
    end
  end

  // read data comes from a register so downstream sees a clean flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_data <= 8'h00;
    end else if (pop) begin
      pop_data <= mem[rptr];
    end
  end

  count_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    count <= `DCI_FIFO_DEPTH) else $error("fifo count above depth");

endmodule

// file: core/dci_fifo_irq.sv
// fifo interrupt control and status logic with data register, apb slave
// Function
// (RULE1) whole register reads zero without irq support
// (RULE2) 32-bit control/status register at 0x10
// (RULE3) bit 31 sticky receive flag, write-one-clear
// (RULE4) receive flag reads zero without receive irqs
// (RULE5) receive level zero disables receive interrupt
// (RULE6) receive irq when count reaches level
// (RULE7) receive irq also when fifo full
// (RULE8) receive level read/write, resets one, reserved
// (RULE9) bit 15 sticky transmit flag, write-one-clear
// (RULE10) transmit flag reads zero without transmit irqs
// (RULE11) transmit level zero disables transmit interrupt
// (RULE12) transmit irq when fewer than level remain
// (RULE13) transmit level read/write, reset zero, receive-tied
// (RULE14) data register feeds transmit, drains receive
// (RULE15) depth code n means 2^n bytes
// (RULE16) receive irq presence follows static input
// (RULE17) port disabled holds interrupt outputs low
// (RULE18) interrupt outputs level, follow flag and enable
// (RULE19) reserved bits read zero, ignore writes
//
// The implementer's own choice: the APB slave port.
`include "dci_defs.svh"

module dci_fifo_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_enable_input,
  input wire logic receive_irq_present_tie,
  input wire logic transmit_irq_present_tie,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic rx_irq,
  output logic tx_irq,
  output logic irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] enable_sync; // port enable pin, [1] is safe to use
  logic [1:0] rxi_sync; // receive irq presence strap
  logic [1:0] txi_sync; // transmit irq presence strap
  logic port_enabled_flag;
  logic receive_irq_implemented;
  logic transmit_irq_implemented;

  // straps are static, so two flops are enough; reset reads absent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_sync <= 2'h0;
      rxi_sync <= 2'h0;
      txi_sync <= 2'h0;
    end else begin
      enable_sync <= {enable_sync[0], port_enable_input};
      rxi_sync <= {rxi_sync[0], receive_irq_present_tie}; // [RULE16]
      txi_sync <= {txi_sync[0], transmit_irq_present_tie};
    end
  end
  assign port_enabled_flag = enable_sync[1];
  assign receive_irq_implemented = rxi_sync[1];
  assign transmit_irq_implemented = txi_sync[1];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  dci_pkg::dci_state_t state; // apb answer sequencing
  logic take; // access phase taken this edge
  logic wr; // write taken
  logic rd; // read taken
  logic hit_feat;
  logic hit_ics;
  logic hit_mask;
  logic hit_data;
  logic ics_present; // register exists at all
  assign take = psel & penable & (state == dci_pkg::DCI_S_IDLE);
  assign wr = take & pwrite;
  assign rd = take & ~pwrite;
  assign hit_feat = (paddr == `DCI_OFS_RX_FEATURE);
  assign hit_ics = (paddr == `DCI_OFS_ICS); // [RULE2]
  assign hit_mask = (paddr == `DCI_OFS_MASK);
  assign hit_data = (paddr == `DCI_OFS_DATA);
  assign ics_present = receive_irq_implemented | transmit_irq_implemented; // [RULE1]

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  logic receive_interrupt_flag;
  logic transmit_interrupt_flag;
  logic [3:0] receive_interrupt_level;
  logic [3:0] transmit_interrupt_level;
  logic mask_rx; // lets the receive flag reach irq
  logic mask_tx; // lets the transmit flag reach irq
  logic ics_wr; // write to the control/status word that is live
  logic [4:0] rx_count;
  logic [4:0] tx_pending; // bytes still to be sent, incl. the one on the port
  logic rx_cond;
  logic tx_cond;
  assign ics_wr = wr & hit_ics & ics_present;

  // level selects; only the documented bit groups are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_interrupt_level <= `DCI_RXL_RESET; // [RULE8]
      transmit_interrupt_level <= `DCI_TXL_RESET; // [RULE13]
    end else if (ics_wr & receive_irq_implemented) begin
      // transmit level is kept with receive presence, as the map prints it
      receive_interrupt_level <= pwdata[`DCI_ICS_RXL_HI:`DCI_ICS_RXL_LO]; // [RULE8]
      transmit_interrupt_level <= pwdata[`DCI_ICS_TXL_HI:`DCI_ICS_TXL_LO]; // [RULE13]
    end
  end

  // interrupt conditions; level zero switches each one off
  assign rx_cond = receive_irq_implemented & (receive_interrupt_level != 4'h0) // [RULE5]
    & ((rx_count >= {1'b0, receive_interrupt_level}) // [RULE6]
    | (rx_count == `DCI_FIFO_DEPTH)); // [RULE7] [RULE15]
  assign tx_cond = transmit_irq_implemented & (transmit_interrupt_level != 4'h0) // [RULE11]
    & (tx_pending < {1'b0, transmit_interrupt_level}); // [RULE12]

  // sticky flags; a condition still true in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_interrupt_flag <= 1'b0;
      transmit_interrupt_flag <= 1'b0;
    end else begin
      if (rx_cond) begin
        receive_interrupt_flag <= 1'b1; // [RULE3] [RULE4]
      end else if (ics_wr & pwdata[`DCI_ICS_RXF]) begin
        receive_interrupt_flag <= 1'b0; // [RULE3]
      end
      if (tx_cond) begin
        transmit_interrupt_flag <= 1'b1; // [RULE9] [RULE10]
      end else if (ics_wr & pwdata[`DCI_ICS_TXF]) begin
        transmit_interrupt_flag <= 1'b0; // [RULE9]
      end
    end
  end

  // mask register, same layout as the flag bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_rx <= 1'b0;
      mask_tx <= 1'b0;
    end else if (wr & hit_mask) begin
      mask_rx <= pwdata[`DCI_ICS_RXF];
      mask_tx <= pwdata[`DCI_ICS_TXF];
    end
  end

  // interrupt outputs, all held low while the port is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      rx_irq <= port_enabled_flag & receive_interrupt_flag; // [RULE17] [RULE18]
      tx_irq <= port_enabled_flag & transmit_interrupt_flag; // [RULE17] [RULE18]
      irq <= port_enabled_flag & ((receive_interrupt_flag & mask_rx)
        | (transmit_interrupt_flag & mask_tx)); // [RULE17]
    end
  end

  // ----------------------------------------------------------------
  // data register and fifos
  // ----------------------------------------------------------------
  logic tx_push;
  logic tx_pop;
  logic [4:0] tx_count;
  logic rx_push;
  logic rx_pop;
  logic [7:0] rx_byte;
  logic rd_byte_ok; // a real byte was popped for the pending read
  logic [4:0] next_rx_count;
  // one byte per access; disabled port drops writes and reads as empty
  assign tx_push = wr & hit_data & port_enabled_flag & (tx_count != `DCI_FIFO_DEPTH); // [RULE14]
  assign tx_pop = (tx_count != 5'h00) & (~tx_valid | tx_ready);
  assign rx_push = rx_valid & rx_ready;
  assign rx_pop = rd & hit_data & port_enabled_flag & (rx_count != 5'h00); // [RULE14]
  assign tx_pending = 5'(tx_count + {4'h0, tx_valid});
  assign next_rx_count = 5'(rx_count + {4'h0, rx_push} - {4'h0, rx_pop});

  dci_byte_fifo u_tx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(tx_push),
    .push_data(pwdata[7:0]),
    .pop(tx_pop),
    .pop_data(tx_data),
    .count(tx_count)
  );

  dci_byte_fifo u_rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(rx_push),
    .push_data(rx_data),
    .pop(rx_pop),
    .pop_data(rx_byte),
    .count(rx_count)
  );

  // transmit port valid; tx_data is the fifo's read register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
    end else if (tx_pop) begin
      tx_valid <= 1'b1;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // receive ready looks one cycle ahead so the last slot is usable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (next_rx_count != `DCI_FIFO_DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  logic [31:0] read_word;

  // read mux; anything not listed reads as zero
  always_comb begin
    read_word = 32'h0000_0000; // [RULE19]
    case (paddr)
      `DCI_OFS_RX_FEATURE: begin
        read_word[`DCI_FEAT_DEPTH_HI:`DCI_FEAT_DEPTH_LO] = `DCI_RX_DEPTH_CODE; // [RULE15]
        read_word[`DCI_FEAT_IRQ] = receive_irq_implemented;
        read_word[`DCI_FEAT_PRESENT] = 1'b1;
      end
      `DCI_OFS_ICS: begin
        if (ics_present) begin // [RULE1]
          read_word[`DCI_ICS_RXF] = receive_interrupt_flag & receive_irq_implemented; // [RULE4]
          if (receive_irq_implemented) begin // [RULE8] [RULE13]
            read_word[`DCI_ICS_RXL_HI:`DCI_ICS_RXL_LO] = receive_interrupt_level;
            read_word[`DCI_ICS_TXL_HI:`DCI_ICS_TXL_LO] = transmit_interrupt_level;
          end
          read_word[`DCI_ICS_TXF] = transmit_interrupt_flag & transmit_irq_implemented; // [RULE10]
        end
      end
      `DCI_OFS_MASK: begin
        read_word[`DCI_ICS_RXF] = mask_rx;
        read_word[`DCI_ICS_TXF] = mask_tx;
      end
      `DCI_OFS_DATA: begin
        // oldest byte low, missing bytes padded with the null byte
        read_word = {`DCI_NULL_BYTE, `DCI_NULL_BYTE, `DCI_NULL_BYTE,
          rd_byte_ok ? rx_byte : `DCI_NULL_BYTE}; // [RULE14]
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // two wait states: the popped byte needs a cycle to reach its register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dci_pkg::DCI_S_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      rd_byte_ok <= 1'b0;
    end else begin
      case (state)
        dci_pkg::DCI_S_IDLE: begin
          if (take) begin
            rd_byte_ok <= rx_pop;
            state <= dci_pkg::DCI_S_LOAD;
          end
        end
        dci_pkg::DCI_S_LOAD: begin
          prdata <= pwrite ? 32'h0000_0000 : read_word;
          pslverr <= ~(hit_feat | hit_ics | hit_mask | hit_data);
          pready <= 1'b1;
          state <= dci_pkg::DCI_S_DONE;
        end
        dci_pkg::DCI_S_DONE: begin
          // master samples pready at this edge and moves on
          pready <= 1'b0;
          pslverr <= 1'b0;
          state <= dci_pkg::DCI_S_IDLE;
        end
        default: begin
          pready <= 1'b0;
          state <= dci_pkg::DCI_S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking dci_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ics_absent_a: assert property ((state == dci_pkg::DCI_S_LOAD) & ~pwrite & hit_ics
    & ~ics_present |=> prdata == 32'h0000_0000) else $error("absent register read nonzero"); // [RULE1]
  ics_read_a: assert property ((state == dci_pkg::DCI_S_LOAD) & ~pwrite & hit_ics
    & receive_irq_implemented |=> prdata[19:16] == $past(receive_interrupt_level)
    && pready) else $error("level field not returned"); // [RULE2]
  rx_sticky_a: assert property (receive_interrupt_flag & ~(ics_wr & pwdata[31])
    |=> receive_interrupt_flag) else $error("receive flag lost"); // [RULE3]
  rx_absent_a: assert property (~receive_irq_implemented |=> ~receive_interrupt_flag
    || $past(receive_interrupt_flag)) else $error("receive flag set while absent"); // [RULE4]
  rx_off_a: assert property ((receive_interrupt_level == 4'h0) & ~receive_interrupt_flag
    |=> ~receive_interrupt_flag) else $error("receive flag set with level zero"); // [RULE5]
  rx_level_a: assert property (receive_irq_implemented & (receive_interrupt_level != 4'h0)
    & (rx_count >= {1'b0, receive_interrupt_level}) |=> receive_interrupt_flag)
    else $error("receive level reached, no flag"); // [RULE6]
  rx_full_a: assert property (receive_irq_implemented & (receive_interrupt_level != 4'h0)
    & (rx_count == 5'h10) |=> receive_interrupt_flag) else $error("full fifo, no flag"); // [RULE7]
  rx_level_wr_a: assert property (ics_wr & receive_irq_implemented
    |=> receive_interrupt_level == $past(pwdata[19:16])) else $error("level not written"); // [RULE8]
  tx_sticky_a: assert property (transmit_interrupt_flag & ~(ics_wr & pwdata[15])
    |=> transmit_interrupt_flag) else $error("transmit flag lost"); // [RULE9]
  tx_absent_a: assert property (~transmit_irq_implemented & ~transmit_interrupt_flag
    |=> ~transmit_interrupt_flag) else $error("transmit flag set while absent"); // [RULE10]
  tx_off_a: assert property ((transmit_interrupt_level == 4'h0) & ~transmit_interrupt_flag
    |=> ~transmit_interrupt_flag) else $error("transmit flag set with level zero"); // [RULE11]
  tx_level_a: assert property (transmit_irq_implemented & (transmit_interrupt_level != 4'h0)
    & (tx_pending < {1'b0, transmit_interrupt_level}) |=> transmit_interrupt_flag)
    else $error("transmit below level, no flag"); // [RULE12]
  tx_tie_a: assert property (ics_wr & ~receive_irq_implemented
    |=> $stable(transmit_interrupt_level)) else $error("transmit level written"); // [RULE13]
  data_null_a: assert property (rd & hit_data & (~port_enabled_flag | (rx_count == 5'h00))
    |=> ##1 prdata == 32'h0000_0000) else $error("empty read not null"); // [RULE14]
  depth_code_a: assert property ((state == dci_pkg::DCI_S_LOAD) & ~pwrite & hit_feat
    |=> prdata[19:16] == 4'h4) else $error("depth code wrong"); // [RULE15]
  strap_a: assert property ($stable(receive_irq_present_tie) [*4]
    |-> receive_irq_implemented == receive_irq_present_tie) else $error("strap not taken"); // [RULE16]
  irq_off_a: assert property (~port_enabled_flag |=> ~rx_irq & ~tx_irq & ~irq)
    else $error("interrupt while disabled"); // [RULE17]
  irq_level_a: assert property (port_enabled_flag & receive_interrupt_flag |=> rx_irq
    ##0 ($past(receive_interrupt_flag) == rx_irq)) else $error("irq not following flag"); // [RULE18]
  reserved_a: assert property (pready & hit_ics |-> prdata[30:20] == 11'h000
    && prdata[14:4] == 11'h000) else $error("reserved bits nonzero"); // [RULE19]

  rx_irq_c: cover property (rx_irq ##1 (ics_wr & pwdata[31]));
  tx_irq_c: cover property (tx_cond ##[1:4] tx_irq);
  rx_full_c: cover property (rx_count == 5'h10);
  data_rd_c: cover property (rx_pop ##2 pready);

endmodule

// file: verif/debug_channel_fifo_interrupts_tb_top.sv
// self-checking bench for the debug channel fifo interrupt block
`include "dci_defs.svh"

module debug_channel_fifo_interrupts_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // stimulus signals, all given a value at time zero
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic port_enable_input = 1'b1;
  logic rx_tie = 1'b1; // receive interrupt strap
  logic tx_tie = 1'b1; // transmit interrupt strap
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic tx_ready = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_ready, tx_valid, rx_irq, tx_irq, irq;
  logic [7:0] tx_data;
  logic [31:0] rd; // last read word
  logic err; // last error response
  int mismatches = 0;
  int check_count = 0;

  // 125 MHz clock
  always #4 pclk = ~pclk;

  dci_fifo_irq dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_enable_input(port_enable_input),
    .receive_irq_present_tie(rx_tie), .transmit_irq_present_tie(tx_tie),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .irq(irq)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // reset held four cycles, then time for the strap synchronisers
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // receive unit offers one byte until it is taken
  task automatic push(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
  endtask

  // flag edge, output edge and enable sync all fit in this span
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values();
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0001_0000);
    apb(1'b0, `DCI_OFS_RX_FEATURE, 32'h0);
    check(rd, 32'h0004_0003);
    apb(1'b0, 12'h100, 32'h0);
    check({31'h0, err}, 32'h1); // unmapped place answers with an error
    // every reserved bit written one, both levels zero
    apb(1'b1, `DCI_OFS_ICS, 32'h7FF0_7FF0);
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0);
  endtask

  // level three: two bytes quiet, third raises, write zero keeps, one clears
  task automatic t_rx_level();
    apb(1'b1, `DCI_OFS_MASK, 32'h8000_0000);
    apb(1'b1, `DCI_OFS_ICS, 32'h0003_0000);
    push(8'hA1);
    push(8'hA2);
    settle();
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0003_0000);
    check({30'h0, rx_irq, irq}, 32'h0);
    push(8'hA3);
    settle();
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h8003_0000);
    check({30'h0, rx_irq, irq}, 32'h3);
    apb(1'b1, `DCI_OFS_MASK, 32'h0);
    settle();
    check({30'h0, rx_irq, irq}, 32'h2); // masked summary line drops
    for (int i = 1; i <= 3; i++) begin
      apb(1'b0, `DCI_OFS_DATA, 32'h0);
      check(rd, {24'h0, 8'hA0 + 8'(i)});
    end
    apb(1'b1, `DCI_OFS_ICS, 32'h0003_0000);
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h8003_0000);
    apb(1'b1, `DCI_OFS_ICS, 32'h8003_0000);
    settle();
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0003_0000);
    check({31'h0, rx_irq}, 32'h0);
  endtask

  // level zero stays quiet even when the fifo fills and refuses
  task automatic t_rx_full();
    apb(1'b1, `DCI_OFS_ICS, 32'h0);
    for (int i = 0; i < 16; i++) push(8'(i) + 8'h40);
    settle();
    check({31'h0, rx_ready}, 32'h0); // fifo full refuses more
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `DCI_OFS_ICS, 32'h000F_0000);
    settle();
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h800F_0000);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, `DCI_OFS_DATA, 32'h0);
      check(rd, {24'h0, 8'(i) + 8'h40});
    end
    // fifo now empty: a further data read gives only null bytes
    apb(1'b0, `DCI_OFS_DATA, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `DCI_OFS_ICS, 32'h8000_0000);
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0);
  endtask

  // tx level two: three pending keep quiet, draining below two raises
  task automatic t_tx_level();
    apb(1'b1, `DCI_OFS_MASK, 32'h0000_8000);
    apb(1'b1, `DCI_OFS_ICS, 32'h0000_0002);
    for (int i = 0; i < 3; i++) apb(1'b1, `DCI_OFS_DATA, {24'h0, 8'hC0 + 8'(i)});
    // clear the flag raised while filling; the level field is rewritten too
    apb(1'b1, `DCI_OFS_ICS, 32'h0000_8002);
    settle();
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0000_0002);
    check({30'h0, tx_irq, irq}, 32'h0);
    tx_ready <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      do @(posedge pclk); while (tx_valid !== 1'b1);
      check({24'h0, tx_data}, {24'h0, 8'hC0 + 8'(i)});
    end
    settle();
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0000_8002);
    check({30'h0, tx_irq, irq}, 32'h3);
  endtask

  // disabled port: outputs low, flag kept, data writes dropped
  task automatic t_disable();
    port_enable_input <= 1'b0;
    settle();
    check({30'h0, tx_irq, irq}, 32'h0);
    apb(1'b1, `DCI_OFS_DATA, 32'h0000_0055);
    settle();
    check({31'h0, tx_valid}, 32'h0); // write ignored while disabled
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0000_8002);
    port_enable_input <= 1'b1;
    settle();
    check({31'h0, tx_irq}, 32'h1);
  endtask

  // receive strap off: receive fields and the tied tx level read zero
  task automatic t_straps();
    rx_tie <= 1'b0;
    do_reset();
    apb(1'b0, `DCI_OFS_RX_FEATURE, 32'h0);
    check(rd, 32'h0004_0001);
    apb(1'b1, `DCI_OFS_ICS, 32'h000F_000F);
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0);
    tx_tie <= 1'b0;
    do_reset();
    apb(1'b1, `DCI_OFS_ICS, 32'h000F_000F);
    apb(1'b0, `DCI_OFS_ICS, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h0);
  endtask

  // ------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_reset_values();
    t_rx_level();
    t_rx_full();
    t_tx_level();
    t_disable();
    t_straps();
    give_verdict();
  end

  // whole run needs a few hundred cycles; this limit is generous
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end
endmodule
